// ===== common/cib_pkg.sv
// constants and types shared by the interrupt and bus-hold block
package cib_pkg;

    // ----------------------------------------------------------------
    // register byte offsets (apb, one word each)
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_FLAGS = 8'h00;
    localparam logic [7:0] OFS_MASK = 8'h04;
    localparam logic [7:0] OFS_ST0 = 8'h08;
    localparam logic [7:0] OFS_ICR = 8'h0C;
    localparam logic [7:0] OFS_EVT_STAT = 8'h10;
    localparam logic [7:0] OFS_EVT_CLR = 8'h14;
    localparam logic [7:0] OFS_EVT_EN = 8'h18;
    localparam logic [7:0] OFS_SAVED_PC = 8'h1C;

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int unsigned GIRQ_DIS_BIT = 9;
    localparam int unsigned EDGE_MODE_BIT = 4;
    localparam logic [15:0] RST_FLAGS = 16'h0000;
    localparam logic [15:0] RST_MASK = 16'h0000;
    localparam logic [15:0] RST_ST0 = 16'h0200;
    localparam logic [15:0] RST_ICR = 16'h0000;
    localparam logic [15:0] RST_PC = 16'h0000;

    // event status bits
    localparam int unsigned EVT_TAKEN = 0;
    localparam int unsigned EVT_GRANT = 1;
    localparam int unsigned EVT_RELEASE = 2;
    localparam int unsigned EVT_W = 3;
    localparam logic [2:0] RST_EVT = 3'h0;

    // ----------------------------------------------------------------
    // vector locations in program memory
    // ----------------------------------------------------------------
    localparam logic [15:0] VEC_TRAP = 16'h0022;
    localparam logic [15:0] VEC_NMI = 16'h0024;
    localparam logic [15:0] VEC_STRIDE = 16'h0002;

    // shared pin is flag bit 0, the two other pins bits 1 and 2
    localparam int unsigned SHARED_PIN_BIT = 0;
    localparam int unsigned PIN_COUNT = 3;

    typedef enum logic [1:0]
    {
        CIB_HS_RUN = 2'b00,
        CIB_HS_ARMED = 2'b01,
        CIB_HS_HOLD = 2'b11
    } cib_hold_state_t;

    typedef enum logic [1:0]
    {
        CIB_REQ_MASKABLE = 2'b00,
        CIB_REQ_SOFT = 2'b01,
        CIB_REQ_TRAP = 2'b11,
        CIB_REQ_NMI = 2'b10
    } cib_req_kind_t;

endpackage : cib_pkg

// ===== common/cib_sync_if.sv
// bundle between the pin synchroniser and the interrupt core
`timescale 1ns/1ps
`default_nettype none
interface cib_sync_if #(parameter int unsigned W = 4);
    logic [W-1:0] raw;
    logic [W-1:0] level;
    logic [W-1:0] fall;
    logic [W-1:0] rise;
    modport sync (input raw, output level, output fall, output rise);
    modport user (output raw, input level, input fall, input rise);
endinterface : cib_sync_if
`default_nettype wire

// ===== verilog/cib_pin_sync.sv
// three-stage pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
`default_nettype none
module cib_pin_sync #(
    parameter int unsigned W = 4
) (
    input wire logic clk_in, // cpu clock
    input wire logic rst_b_in, // sync reset, active low
    input wire logic ce_in, // clock enable
    cib_sync_if.sync pins // raw pins in, levels and edges out
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] level_q;
    logic [W-1:0] fall_q;
    logic [W-1:0] rise_q;
    logic [W-1:0] agree;

    // pins idle high; a change counts only once stages two and three agree
    assign agree = ~(s2_q ^ s3_q);

    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            s1_q <= '1;
            s2_q <= '1;
            s3_q <= '1;
        end
        else if (ce_in)
        begin
            s1_q <= pins.raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            level_q <= '1;
            fall_q <= '0;
            rise_q <= '0;
        end
        else if (ce_in)
        begin
            level_q <= (agree & s3_q) | (~agree & level_q);
            fall_q <= agree & ~s3_q & level_q;
            rise_q <= agree & s3_q & ~level_q;
        end
    end

    assign pins.level = level_q;
    assign pins.fall = fall_q;
    assign pins.rise = rise_q;
endmodule : cib_pin_sync
`default_nettype wire

// ===== verilog/cib_irq_hold.sv
// maskable interrupt controller with vectoring and external bus-hold handshake
//
// Functional notes
// - sixteen-bit pending flag register readable by software.
// - writing one to a flag bit clears it; zeros leave bits alone.
// - sixteen-bit enable mask register, one bit per source.
// - source interrupts only when its mask bit is one and global disable zero.
// - status word zero bit 9 set disables all maskable interrupts.
// - requests come from four pins, peripherals, and three instruction kinds.
// - acknowledged interrupt branches to its fixed vector location.
// - acknowledge output asserted while the vector is being fetched.
// - hold starts as shared-pin interrupt; grant and float only after idle.
// - buses return to drive and hold ends when processor leaves idle.
// - master requests with pin low; keeps buses until pin high or nmi.
// - while grant is low, address, data and control lines are released.
// - nonmaskable interrupt ignores the mask and the global disable bit.
// - control bit 4 selects falling-only or both edges on shared pin.
// - only the program counter is saved and restored automatically.
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/1ps
`default_nettype none
module cib_irq_hold #(
    parameter int unsigned NSRC = 16, // maskable sources
    parameter int unsigned NPERIPH = 13 // on-chip peripheral sources
) (
    input wire logic clk_in, // cpu clock, 250 MHz
    input wire logic rst_b_in, // sync reset, active low
    input wire logic ce_in, // clock enable
    input wire logic [7:0] paddr_in, // apb address
    input wire logic psel_in, // apb select
    input wire logic penable_in, // apb enable
    input wire logic pwrite_in, // apb direction
    input wire logic [31:0] pwdata_in, // apb write data
    output logic [31:0] prdata_out, // apb read data
    output logic pready_out, // apb ready
    output logic pslverr_out, // apb error
    input wire logic shared_request_irq_pin_n_in, // bus request / irq one pin
    input wire logic [1:0] external_irq_pins_n_in, // irq two and three pins
    input wire logic nmi_pin_n_in, // nonmaskable pin
    input wire logic [NPERIPH-1:0] periph_irq_in, // peripheral request pulses
    input wire logic software_irq_instruction_in, // software irq pulse
    input wire logic [4:0] software_irq_num_in, // its vector number
    input wire logic trap_instr_in, // trap instruction pulse
    input wire logic nmi_instr_in, // nmi instruction pulse
    input wire logic [15:0] cpu_pc_in, // pc to save
    input wire logic cpu_irq_accept_in, // request taken
    input wire logic cpu_return_in, // return from service routine
    input wire logic cpu_idle_in, // processor in idle state
    output logic cpu_irq_req_out, // request to sequencer
    output logic [15:0] cpu_vector_addr_out, // vector to fetch
    output logic vector_fetch_ack_out, // vector fetch acknowledge
    output logic [15:0] restore_pc_out, // saved program counter
    output logic restore_pc_valid_out, // restore pulse
    output logic bus_grant_n_out, // bus grant, active low
    output logic bus_drive_en_out, // drive external buses
    output logic irq_out // event interrupt, level
);
    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    cib_sync_if #(.W(cib_pkg::PIN_COUNT + 1)) pins ();

    assign pins.raw = {nmi_pin_n_in, external_irq_pins_n_in, shared_request_irq_pin_n_in};

    cib_pin_sync #(.W(cib_pkg::PIN_COUNT + 1)) u_sync (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .ce_in(ce_in),
        .pins(pins)
    );

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    function automatic logic [15:0] vec_of(input logic [4:0] num);
        vec_of = 16'(num) * cib_pkg::VEC_STRIDE;
    endfunction : vec_of

    function automatic logic [4:0] lowest_set(input logic [NSRC-1:0] v);
        lowest_set = '0;
        for (int i = NSRC - 1; i >= 0; i--)
        begin
            if (v[i])
            begin
                lowest_set = 5'(i);
            end
        end
    endfunction : lowest_set

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [NSRC-1:0] flags_q;
    logic [NSRC-1:0] flags_d;
    logic [NSRC-1:0] mask_q;
    logic [15:0] st0_q;
    logic [15:0] icr_q;
    logic [cib_pkg::EVT_W-1:0] evt_q;
    logic [cib_pkg::EVT_W-1:0] evt_en_q;
    logic [15:0] saved_pc_q;
    logic nmi_pend_q;
    logic trap_pend_q;
    logic soft_pend_q;
    logic [4:0] soft_num_q;
    logic req_q;
    logic [15:0] vec_q;
    cib_pkg::cib_req_kind_t kind_q;
    logic [4:0] src_q;
    logic ack_q;
    logic [15:0] rpc_q;
    logic rpc_v_q;
    cib_pkg::cib_hold_state_t hs_q;
    cib_pkg::cib_hold_state_t hs_d;
    logic grant_n_q;
    logic drive_q;
    logic irq_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;

    logic wr_en;
    logic setup;
    logic girq_dis;
    logic edge_both;
    logic shared_evt;
    logic nmi_evt;
    logic accept;
    logic [NSRC-1:0] set_vec;
    logic [NSRC-1:0] clr_vec;
    logic [NSRC-1:0] eligible;
    logic [cib_pkg::EVT_W-1:0] evt_set;

    assign setup = psel_in & ~penable_in & ~pready_q;
    assign wr_en = psel_in & penable_in & pready_q & pwrite_in;
    assign girq_dis = st0_q[cib_pkg::GIRQ_DIS_BIT];
    assign edge_both = icr_q[cib_pkg::EDGE_MODE_BIT];
    assign accept = cpu_irq_accept_in & req_q;
    assign nmi_evt = pins.fall[cib_pkg::PIN_COUNT] | nmi_instr_in;

    // ----------------------------------------------------------------
    // pending flags
    // ----------------------------------------------------------------
    // falling edge always counts; rising edge only in both-edge mode
    assign shared_evt = pins.fall[cib_pkg::SHARED_PIN_BIT]
                      | (edge_both & pins.rise[cib_pkg::SHARED_PIN_BIT]);

    always_comb
    begin
        set_vec = '0;
        set_vec[cib_pkg::SHARED_PIN_BIT] = shared_evt;
        set_vec[cib_pkg::PIN_COUNT-1:1] = pins.fall[cib_pkg::PIN_COUNT-1:1];
        set_vec[NSRC-1:cib_pkg::PIN_COUNT] = periph_irq_in;
        clr_vec = '0;
        if (wr_en && paddr_in == cib_pkg::OFS_FLAGS)
        begin
            clr_vec = pwdata_in[NSRC-1:0];
        end
        if (accept && kind_q == cib_pkg::CIB_REQ_MASKABLE)
        begin
            clr_vec[src_q[3:0]] = 1'b1;
        end
        // a new request in the clearing cycle survives
        flags_d = (flags_q & ~clr_vec) | set_vec;
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            flags_q <= cib_pkg::RST_FLAGS;
        end
        else if (ce_in)
        begin
            flags_q <= flags_d;
        end
    end

    // ----------------------------------------------------------------
    // software-written control registers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            mask_q <= cib_pkg::RST_MASK;
            st0_q <= cib_pkg::RST_ST0;
            icr_q <= cib_pkg::RST_ICR;
            evt_en_q <= cib_pkg::RST_EVT;
        end
        else if (ce_in && wr_en)
        begin
            unique case (paddr_in)
                cib_pkg::OFS_MASK: mask_q <= pwdata_in[NSRC-1:0];
                cib_pkg::OFS_ST0: st0_q <= pwdata_in[15:0];
                cib_pkg::OFS_ICR: icr_q <= pwdata_in[15:0];
                cib_pkg::OFS_EVT_EN: evt_en_q <= pwdata_in[cib_pkg::EVT_W-1:0];
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // instruction and nonmaskable requests
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            nmi_pend_q <= 1'b0;
            trap_pend_q <= 1'b0;
            soft_pend_q <= 1'b0;
            soft_num_q <= '0;
        end
        else if (ce_in)
        begin
            nmi_pend_q <= nmi_evt | (nmi_pend_q & ~(accept && kind_q == cib_pkg::CIB_REQ_NMI));
            trap_pend_q <= trap_instr_in | (trap_pend_q & ~(accept && kind_q == cib_pkg::CIB_REQ_TRAP));
            soft_pend_q <= software_irq_instruction_in
                         | (soft_pend_q & ~(accept && kind_q == cib_pkg::CIB_REQ_SOFT));
            if (software_irq_instruction_in)
            begin
                soft_num_q <= software_irq_num_in;
            end
        end
    end

    // ----------------------------------------------------------------
    // request selection: nmi, trap, software, then lowest maskable
    // ----------------------------------------------------------------
    // mask and global disable gate only the maskable flags
    assign eligible = flags_q & mask_q & {NSRC{~girq_dis}};

    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            req_q <= 1'b0;
            vec_q <= '0;
            kind_q <= cib_pkg::CIB_REQ_MASKABLE;
            src_q <= '0;
        end
        else if (ce_in)
        begin
            // one cycle of settling after an accept avoids re-offering a stale request
            req_q <= ~accept & (nmi_pend_q | trap_pend_q | soft_pend_q | (|eligible));
            if (nmi_pend_q)
            begin
                vec_q <= cib_pkg::VEC_NMI;
                kind_q <= cib_pkg::CIB_REQ_NMI;
            end
            else if (trap_pend_q)
            begin
                vec_q <= cib_pkg::VEC_TRAP;
                kind_q <= cib_pkg::CIB_REQ_TRAP;
            end
            else if (soft_pend_q)
            begin
                vec_q <= vec_of(soft_num_q);
                kind_q <= cib_pkg::CIB_REQ_SOFT;
            end
            else
            begin
                vec_q <= vec_of(5'(lowest_set(eligible) + 5'd1));
                kind_q <= cib_pkg::CIB_REQ_MASKABLE;
            end
            src_q <= lowest_set(eligible);
        end
    end

    // ----------------------------------------------------------------
    // acknowledge and program counter save / restore
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            ack_q <= 1'b0;
            saved_pc_q <= cib_pkg::RST_PC;
            rpc_q <= cib_pkg::RST_PC;
            rpc_v_q <= 1'b0;
        end
        else if (ce_in)
        begin
            ack_q <= accept;
            rpc_v_q <= cpu_return_in;
            if (accept)
            begin
                saved_pc_q <= cpu_pc_in;
            end
            if (cpu_return_in)
            begin
                rpc_q <= saved_pc_q;
            end
        end
    end

    // ----------------------------------------------------------------
    // bus hold handshake
    // ----------------------------------------------------------------
    always_comb
    begin
        hs_d = hs_q;
        unique case (hs_q)
            cib_pkg::CIB_HS_RUN:
                if (!pins.level[cib_pkg::SHARED_PIN_BIT])
                begin
                    hs_d = cib_pkg::CIB_HS_ARMED;
                end
            cib_pkg::CIB_HS_ARMED:
                if (pins.level[cib_pkg::SHARED_PIN_BIT])
                begin
                    hs_d = cib_pkg::CIB_HS_RUN;
                end
                else if (cpu_idle_in)
                begin
                    hs_d = cib_pkg::CIB_HS_HOLD;
                end
            cib_pkg::CIB_HS_HOLD:
                if (!cpu_idle_in || pins.level[cib_pkg::SHARED_PIN_BIT] || nmi_evt)
                begin
                    hs_d = cib_pkg::CIB_HS_RUN;
                end
            default:
                hs_d = cib_pkg::CIB_HS_RUN;
        endcase
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            hs_q <= cib_pkg::CIB_HS_RUN;
            grant_n_q <= 1'b1;
            drive_q <= 1'b1;
        end
        else if (ce_in)
        begin
            hs_q <= hs_d;
            grant_n_q <= hs_d != cib_pkg::CIB_HS_HOLD;
            drive_q <= hs_d != cib_pkg::CIB_HS_HOLD;
        end
    end

    // ----------------------------------------------------------------
    // event status and interrupt line
    // ----------------------------------------------------------------
    always_comb
    begin
        evt_set = '0;
        evt_set[cib_pkg::EVT_TAKEN] = accept;
        evt_set[cib_pkg::EVT_GRANT] = hs_q != cib_pkg::CIB_HS_HOLD && hs_d == cib_pkg::CIB_HS_HOLD;
        evt_set[cib_pkg::EVT_RELEASE] = hs_q == cib_pkg::CIB_HS_HOLD && hs_d != cib_pkg::CIB_HS_HOLD;
    end

    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            evt_q <= cib_pkg::RST_EVT;
            irq_q <= 1'b0;
        end
        else if (ce_in)
        begin
            // set wins over a clear in the same cycle
            if (wr_en && paddr_in == cib_pkg::OFS_EVT_CLR)
            begin
                evt_q <= (evt_q & ~pwdata_in[cib_pkg::EVT_W-1:0]) | evt_set;
            end
            else
            begin
                evt_q <= evt_q | evt_set;
            end
            irq_q <= |(evt_q & evt_en_q);
        end
    end

    // ----------------------------------------------------------------
    // apb slave: one wait-free access cycle after setup
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            prdata_q <= '0;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
        end
        else if (ce_in)
        begin
            pready_q <= setup;
            if (setup)
            begin
                pslverr_q <= 1'b0;
                prdata_q <= '0;
                unique case (paddr_in)
                    cib_pkg::OFS_FLAGS: prdata_q <= 32'(flags_q);
                    cib_pkg::OFS_MASK: prdata_q <= 32'(mask_q);
                    cib_pkg::OFS_ST0: prdata_q <= 32'(st0_q);
                    cib_pkg::OFS_ICR: prdata_q <= 32'(icr_q);
                    cib_pkg::OFS_EVT_STAT: prdata_q <= 32'(evt_q);
                    cib_pkg::OFS_EVT_CLR: prdata_q <= '0;
                    cib_pkg::OFS_EVT_EN: prdata_q <= 32'(evt_en_q);
                    cib_pkg::OFS_SAVED_PC: prdata_q <= 32'(saved_pc_q);
                    default: pslverr_q <= 1'b1;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign prdata_out = prdata_q;
    assign pready_out = pready_q;
    assign pslverr_out = pslverr_q;
    assign cpu_irq_req_out = req_q;
    assign cpu_vector_addr_out = vec_q;
    assign vector_fetch_ack_out = ack_q;
    assign restore_pc_out = rpc_q;
    assign restore_pc_valid_out = rpc_v_q;
    assign bus_grant_n_out = grant_n_q;
    assign bus_drive_en_out = drive_q;
    assign irq_out = irq_q;
endmodule : cib_irq_hold
`default_nettype wire

// ===== tb/cib_irq_hold_checker.sv
// assertion checker for the interrupt and bus-hold block
`timescale 1ns/1ps
`default_nettype none
module cib_irq_hold_checker (
    input wire logic clk_in, // clock
    input wire logic rst_b_in, // reset
    input wire logic psel_in, // apb select
    input wire logic penable_in, // apb enable
    input wire logic pready_out, // apb ready
    input wire logic cpu_irq_req_out, // cpu request
    input wire logic cpu_irq_accept_in, // cpu accept
    input wire logic vector_fetch_ack_out, // fetch ack
    input wire logic cpu_idle_in, // idle
    input wire logic cpu_return_in, // return
    input wire logic restore_pc_valid_out, // restore
    input wire logic bus_grant_n_out, // grant
    input wire logic bus_drive_en_out // bus drive
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    a_apb_ready_next: assert property (psel_in && !penable_in |=> pready_out)
        else $error("no ready after setup");
    a_ready_in_access: assert property (pready_out |-> psel_in && penable_in)
        else $error("ready outside access");
    a_ack_after_accept: assert property (cpu_irq_req_out && cpu_irq_accept_in |=> vector_fetch_ack_out && !cpu_irq_req_out)
        else $error("no fetch ack");
    a_ack_has_cause: assert property (vector_fetch_ack_out |-> $past(cpu_irq_accept_in && cpu_irq_req_out))
        else $error("stray fetch ack");
    a_grant_after_idle: assert property ($fell(bus_grant_n_out) |-> $past(cpu_idle_in))
        else $error("grant without idle");
    a_grant_ends_idle: assert property (!bus_grant_n_out && !cpu_idle_in |=> bus_grant_n_out)
        else $error("grant kept after idle");
    a_float_with_grant: assert property (bus_drive_en_out == bus_grant_n_out)
        else $error("bus drive disagrees with grant");
    a_restore_after_ret: assert property (cpu_return_in |=> restore_pc_valid_out)
        else $error("no pc restore");
    c_ack: cover property (vector_fetch_ack_out);
    c_grant: cover property ($fell(bus_grant_n_out));
    c_restore: cover property (restore_pc_valid_out);
endmodule : cib_irq_hold_checker
bind cib_irq_hold cib_irq_hold_checker u_chk (.*);
`default_nettype wire

// ===== tb/cib_ext_parts.sv
// model of the external interrupt sources and the bus master
`timescale 1ns/1ps
`default_nettype none
module cib_ext_parts (
    input wire logic hold_want_in, // master wants the buses
    input wire logic [1:0] irq_want_in, // pin requests
    input wire logic nmi_want_in, // nmi request
    output logic shared_pin_n_out, // request / irq one
    output logic [1:0] irq_pins_n_out, // irq two and three
    output logic nmi_pin_n_out // nmi pin
);
    // pulled-up pins: an idle source reads high, never floats
    assign shared_pin_n_out = !hold_want_in;
    assign irq_pins_n_out = ~irq_want_in;
    assign nmi_pin_n_out = !nmi_want_in;
endmodule : cib_ext_parts
`default_nettype wire

// ===== tb/tb.sv
// self-checking bench for the interrupt and bus-hold block
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk_in = 1'b0, rst_b_in = 1'b0, ce_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
    logic [7:0] paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0000_0000, prdata_out, q;
    logic pready_out, pslverr_out, cpu_irq_req_out, vector_fetch_ack_out, restore_pc_valid_out, e;
    logic bus_grant_n_out, bus_drive_en_out, irq_out, hold = 1'b0, nmi = 1'b0;
    logic [15:0] cpu_vector_addr_out, restore_pc_out, cpu_pc_in = 16'h1234;
    logic [15:0] vec [3] = '{16'h0024, 16'h0022, 16'h000a};
    logic [12:0] periph_irq_in = 13'h0000;
    logic [4:0] software_irq_num_in = 5'h05;
    logic software_irq_instruction_in = 1'b0, trap_instr_in = 1'b0, nmi_instr_in = 1'b0;
    logic cpu_irq_accept_in = 1'b0, cpu_return_in = 1'b0, cpu_idle_in = 1'b0;
    logic [1:0] irqs = 2'b00;
    wire shared_request_irq_pin_n_in, nmi_pin_n_in;
    wire [1:0] external_irq_pins_n_in;
    int error_cnt = 0, tests_run = 0;
    cib_irq_hold uut (.*);
    cib_ext_parts ext (.hold_want_in(hold), .irq_want_in(irqs), .nmi_want_in(nmi),
        .shared_pin_n_out(shared_request_irq_pin_n_in), .irq_pins_n_out(external_irq_pins_n_in),
        .nmi_pin_n_out(nmi_pin_n_in));
    always #2 clk_in = ~clk_in;
    task finish_test;
        $display("mismatches %0d, checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : finish_test
    task chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h, want %h", $time, got, exp);
        end
    endtask : chk
    // request held until pready is seen high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do @(posedge clk_in); while (pready_out !== 1'b1 && ++n < 50);
        q = prdata_out;
        e = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask : apb
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0000_0000);
        chk(q, x);
    endtask : rd
    task automatic wt(ref logic s, input logic v);
        int n = 0;
        do @(posedge clk_in); while (s !== v && ++n < 40);
        chk(s, v);
    endtask : wt
    task take(input logic [15:0] v);
        wt(cpu_irq_req_out, 1'b1);
        chk(cpu_vector_addr_out, v);
        cpu_irq_accept_in <= 1'b1;
        @(posedge clk_in);
        cpu_irq_accept_in <= 1'b0;
        @(posedge clk_in);
        chk(vector_fetch_ack_out, 1'b1);
    endtask : take
    task t_regs;
        rd(cib_pkg::OFS_FLAGS, 32'h0000_0000);
        rd(cib_pkg::OFS_ST0, 32'h0000_0200);
        wr(cib_pkg::OFS_MASK, 32'h0000_ffff);
        rd(cib_pkg::OFS_MASK, 32'h0000_ffff);
        rd(8'h20, 32'h0000_0000);
        chk(e, 1'b1);
    endtask : t_regs
    task t_mask;
        @(posedge clk_in);
        periph_irq_in <= 13'h0001;
        @(posedge clk_in);
        periph_irq_in <= 13'h0000;
        repeat (8) @(posedge clk_in);
        chk(cpu_irq_req_out, 1'b0);
        wr(cib_pkg::OFS_FLAGS, 32'h0000_0000);
        rd(cib_pkg::OFS_FLAGS, 32'h0000_0008);
        wr(cib_pkg::OFS_ST0, 32'h0000_0000);
        wt(cpu_irq_req_out, 1'b1);
        wr(cib_pkg::OFS_MASK, 32'h0000_fff7);
        wt(cpu_irq_req_out, 1'b0);
        wr(cib_pkg::OFS_FLAGS, 32'h0000_0008);
        rd(cib_pkg::OFS_FLAGS, 32'h0000_0000);
    endtask : t_mask
    task t_take;
        wr(cib_pkg::OFS_EVT_EN, 32'h0000_0001);
        irqs <= 2'b01;
        take(16'h0004);
        irqs <= 2'b00;
        rd(cib_pkg::OFS_FLAGS, 32'h0000_0000);
        chk(irq_out, 1'b1);
        wr(cib_pkg::OFS_EVT_CLR, 32'h0000_0001);
        rd(cib_pkg::OFS_EVT_STAT, 32'h0000_0000);
        chk(irq_out, 1'b0);
    endtask : t_take
    task t_instr;
        wr(cib_pkg::OFS_ST0, 32'h0000_0200);
        wr(cib_pkg::OFS_MASK, 32'h0000_0000);
        for (int i = 0; i < 3; i++)
        begin
            @(posedge clk_in);
            {nmi_instr_in, trap_instr_in, software_irq_instruction_in} <= 3'h4 >> i;
            @(posedge clk_in);
            {nmi_instr_in, trap_instr_in, software_irq_instruction_in} <= 3'h0;
            take(vec[i]);
        end
        cpu_return_in <= 1'b1;
        @(posedge clk_in);
        cpu_return_in <= 1'b0;
        @(posedge clk_in);
        chk(restore_pc_out, 16'h1234);
    endtask : t_instr
    task t_hold;
        wr(cib_pkg::OFS_ICR, 32'h0000_0010);
        hold <= 1'b1;
        repeat (8) @(posedge clk_in);
        chk(bus_grant_n_out, 1'b1);
        cpu_idle_in <= 1'b1;
        wt(bus_grant_n_out, 1'b0);
        chk(bus_drive_en_out, 1'b0);
        cpu_idle_in <= 1'b0;
        wt(bus_grant_n_out, 1'b1);
        wr(cib_pkg::OFS_FLAGS, 32'h0000_0001);
        hold <= 1'b0;
        repeat (8) @(posedge clk_in);
        rd(cib_pkg::OFS_FLAGS, 32'h0000_0001);
        hold <= 1'b1;
        cpu_idle_in <= 1'b1;
        wt(bus_grant_n_out, 1'b0);
        hold <= 1'b0;
        wt(bus_grant_n_out, 1'b1);
        hold <= 1'b1;
        wt(bus_grant_n_out, 1'b0);
        nmi <= 1'b1;
        wt(bus_grant_n_out, 1'b1);
        take(16'h0024);
        cpu_idle_in <= 1'b0;
    endtask : t_hold
    initial
    begin
        repeat (20) @(posedge clk_in);
        rst_b_in <= 1'b1;
        t_regs();
        t_mask();
        t_take();
        t_instr();
        t_hold();
        finish_test();
    end
    // the run needs under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge clk_in);
        error_cnt++;
        finish_test();
    end
endmodule : tb
`default_nettype wire
